// >>> design/failover_pkg.sv
// Purpose: Shared constants for the network command failover block
// Assumes: 50 MHz ref_clk, word-addressed Avalon-MM register window
// Notes:   Byte address of a register is four times its index

package failover_pkg;

   // ***************************************************
   // Clock and timing
   // ***************************************************
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned DROPOUT_STEP_MS = 500;
   localparam int unsigned STEP_CYCLES = (CLK_HZ / 1000) * DROPOUT_STEP_MS;
   localparam logic [6:0] DROPOUT_MIN = 7'h01;
   localparam logic [6:0] DROPOUT_MAX = 7'h64;
   localparam logic [6:0] DROPOUT_RST = 7'h04;
   localparam logic [1:0] MSG_NEEDED = 2'h3;
   localparam logic [1:0] RECOVER_MULT = 2'h3;

   // ***************************************************
   // Register indices
   // ***************************************************
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_DROPOUT = 3'h1;
   localparam logic [2:0] REG_POLARITY = 3'h2;
   localparam logic [2:0] REG_CAL_KEY = 3'h3;
   localparam logic [2:0] REG_PHASE = 3'h4;
   localparam logic [2:0] REG_SAVE = 3'h5;
   localparam logic [2:0] REG_STATUS = 3'h6;
   localparam logic [2:0] REG_STORED = 3'h7;

   // ***************************************************
   // Field positions and reset values
   // ***************************************************
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_DS_BIT = 1;
   localparam int CTRL_CBAUX_BIT = 2;
   localparam int CTRL_RR_BIT = 3;
   localparam int CTRL_PS_BIT = 4;
   localparam int CTRL_HOLD_BIT = 5;
   localparam logic [5:0] CTRL_RST = 6'h1F;
   localparam logic [7:0] CAL_UNLOCK = 8'h31;
   localparam logic [15:0] PHASE_RST = 16'h0000;
   localparam logic POLARITY_RST = 1'b0;

   // ***************************************************
   // Source monitor codes
   // ***************************************************
   localparam logic [1:0] MON_HARDWARE = 2'h1;
   localparam logic [1:0] MON_NETWORK = 2'h2;
   localparam logic [1:0] MON_FAULT = 2'h3;

   typedef enum logic [3:0] {
      ST_NET    = 4'b0001,
      ST_REVERT = 4'b0010,
      ST_HOLD   = 4'b0100,
      ST_HWLOOP = 4'b1000
   } revert_state_t;

endpackage

// >>> design/network_command_failover.sv
// Purpose: Pick network or hardware command inputs and drive breaker open
// Assumes: Pins pass a three-stage synchroniser; msg_valid is on ref_clk
// Notes:   Stored image registers model storage that survives rst_n
//
// Implementation choices: the register offsets and the Avalon-MM slave port.

`timescale 1ns/10ps
`default_nettype none

module network_command_failover #(
   parameter int DS_W = 8,
   parameter int ANA_W = 12,
   parameter int unsigned STEP_CYCLES = failover_pkg::STEP_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [2:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic msg_valid,
   input wire logic [DS_W-1:0] net_ds_cmd,
   input wire logic net_cbaux_cmd,
   input wire logic [1:0] net_rr_cmd,
   input wire logic net_ps_cmd,
   input wire logic [ANA_W-1:0] net_analog_cmd,
   input wire logic [DS_W-1:0] hw_ds_in,
   input wire logic hw_cbaux_in,
   input wire logic [1:0] hw_rr_in,
   input wire logic hw_ps_in,
   input wire logic [ANA_W-1:0] hw_analog_in,
   input wire logic utility_unload_in,
   input wire logic cpu_ok_in,
   output logic [DS_W-1:0] ds_cmd_out,
   output logic cbaux_cmd_out,
   output logic [1:0] rr_cmd_out,
   output logic ps_cmd_out,
   output logic [ANA_W-1:0] analog_cmd_out,
   output logic breaker_open_out,
   output logic [1:0] input_source_monitor,
   output logic net_match_flag,
   output logic hw_match_flag
);

   // ***************************************************
   // Pin synchronisers
   // ***************************************************
   localparam int PIN_W = DS_W + ANA_W + 6;

   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_clean;
   logic [DS_W-1:0] hw_ds;
   logic hw_cbaux;
   logic [1:0] hw_rr;
   logic hw_ps;
   logic [ANA_W-1:0] hw_analog;
   logic unload;
   logic cpu_ok;

   assign pin_raw = {cpu_ok_in, utility_unload_in, hw_analog_in, hw_ps_in, hw_rr_in, hw_cbaux_in, hw_ds_in};
   assign {cpu_ok, unload, hw_analog, hw_ps, hw_rr, hw_cbaux, hw_ds} = pin_clean;

   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++)
      begin : g_sync
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic clean_reg;
         always_ff @(posedge ref_clk)
         begin
            if (!rst_n)
            begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               clean_reg <= 1'b0;
            end
            else
            begin
               s1_reg <= pin_raw[gi];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               // Change accepted only once stages two and three agree
               if (s2_reg == s3_reg)
                  clean_reg <= s2_reg;
            end
         end
         assign pin_clean[gi] = clean_reg;
      end
   endgenerate

   // ***************************************************
   // Register file
   // ***************************************************
   logic [5:0] ctrl_reg;
   logic [6:0] dropout_pend_reg;
   logic polarity_pend_reg;
   logic [7:0] cal_key_reg;
   logic [15:0] phase_pend_reg;
   // Stored image survives rst_n, like nonvolatile storage
   logic [6:0] dropout_nv_reg = failover_pkg::DROPOUT_RST;
   logic polarity_nv_reg = failover_pkg::POLARITY_RST;
   logic [15:0] phase_nv_reg = failover_pkg::PHASE_RST;
   logic [6:0] dropout_act_reg;
   logic polarity_act_reg;
   logic boot_reg;
   logic net_ok_reg;
   logic [31:0] rd_next;
   logic bus_req;
   logic bus_do_wr;
   logic save_hit;

   assign bus_req = avs_read | avs_write;
   assign bus_do_wr = avs_write & ~avs_waitrequest;
   assign save_hit = bus_do_wr & (avs_address == failover_pkg::REG_SAVE) & avs_writedata[0];

   // One wait state, then a one-cycle acknowledge
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         avs_waitrequest <= 1'b1;
      else if (bus_req & avs_waitrequest)
         avs_waitrequest <= 1'b0;
      else
         avs_waitrequest <= 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ctrl_reg <= failover_pkg::CTRL_RST;
         dropout_pend_reg <= failover_pkg::DROPOUT_RST;
         polarity_pend_reg <= failover_pkg::POLARITY_RST;
         cal_key_reg <= 8'h00;
         phase_pend_reg <= failover_pkg::PHASE_RST;
      end
      else if (bus_do_wr)
      begin
         case (avs_address)
            failover_pkg::REG_CTRL: ctrl_reg <= avs_writedata[5:0];
            failover_pkg::REG_DROPOUT:
               // Out-of-range steps are refused, old value kept
               if (avs_writedata[6:0] >= failover_pkg::DROPOUT_MIN &&
                   avs_writedata[6:0] <= failover_pkg::DROPOUT_MAX && avs_writedata[31:7] == 25'h000_0000)
                  dropout_pend_reg <= avs_writedata[6:0];
            failover_pkg::REG_POLARITY: polarity_pend_reg <= avs_writedata[0];
            failover_pkg::REG_CAL_KEY: cal_key_reg <= avs_writedata[7:0];
            failover_pkg::REG_PHASE:
               if (cal_key_reg == failover_pkg::CAL_UNLOCK)
                  phase_pend_reg <= avs_writedata[15:0];
            default: ;
         endcase
      end
   end

   // Save key commits the pending image
   always_ff @(posedge ref_clk)
   begin
      if (save_hit)
      begin
         dropout_nv_reg <= dropout_pend_reg;
         polarity_nv_reg <= polarity_pend_reg;
         phase_nv_reg <= phase_pend_reg;
      end
   end

   // Stored dropout and polarity go live only on the first cycle after reset
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         boot_reg <= 1'b1;
         dropout_act_reg <= failover_pkg::DROPOUT_RST;
         polarity_act_reg <= failover_pkg::POLARITY_RST;
      end
      else
      begin
         boot_reg <= 1'b0;
         if (boot_reg)
         begin
            dropout_act_reg <= dropout_nv_reg;
            polarity_act_reg <= polarity_nv_reg;
         end
      end
   end

   always_comb
   begin
      rd_next = 32'h0000_0000;
      case (avs_address)
         failover_pkg::REG_CTRL: rd_next[5:0] = ctrl_reg;
         failover_pkg::REG_DROPOUT: rd_next[6:0] = dropout_pend_reg;
         failover_pkg::REG_POLARITY: rd_next[0] = polarity_pend_reg;
         failover_pkg::REG_CAL_KEY: rd_next[7:0] = cal_key_reg;
         failover_pkg::REG_PHASE: rd_next[15:0] = phase_pend_reg;
         failover_pkg::REG_STATUS:
            rd_next[15:0] = {1'b0, dropout_act_reg, 2'b00, polarity_act_reg, hw_match_flag,
                             net_match_flag, net_ok_reg, input_source_monitor};
         failover_pkg::REG_STORED: rd_next[23:0] = {phase_nv_reg, polarity_nv_reg, dropout_nv_reg};
         default: rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read & avs_waitrequest)
         avs_readdata <= rd_next;
   end

   // ***************************************************
   // Network health
   // ***************************************************
   logic [31:0] tick_cnt_reg;
   logic tick;
   logic [8:0] win_cnt_reg;
   logic [8:0] win_len;
   logic [1:0] msg_cnt_reg;
   logic win_end;
   logic enough;

   assign tick = (tick_cnt_reg == STEP_CYCLES - 32'h0000_0001);
   // Failed network listens over a tripled window
   assign win_len = net_ok_reg ? {2'b00, dropout_act_reg} : 9'(dropout_act_reg * failover_pkg::RECOVER_MULT);
   assign win_end = tick & (win_cnt_reg >= win_len - 9'h001);
   assign enough = (msg_cnt_reg == failover_pkg::MSG_NEEDED) |
                   (msg_valid & (msg_cnt_reg == failover_pkg::MSG_NEEDED - 2'h1));

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || tick)
         tick_cnt_reg <= 32'h0000_0000;
      else
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || win_end)
         win_cnt_reg <= 9'h000;
      else if (tick)
         win_cnt_reg <= win_cnt_reg + 9'h001;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || win_end)
         msg_cnt_reg <= 2'h0;
      else if (msg_valid && msg_cnt_reg != failover_pkg::MSG_NEEDED)
         msg_cnt_reg <= msg_cnt_reg + 2'h1;
   end

   // Starts healthy; judged only at each window end
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         net_ok_reg <= 1'b1;
      else if (win_end)
         net_ok_reg <= enough;
   end

   // ***************************************************
   // Revert policy
   // ***************************************************
   logic [DS_W-1:0] last_ds_reg;
   logic last_cbaux_reg;
   logic [ANA_W-1:0] last_ana_reg;
   logic [1:0] last_rr_reg;
   logic last_ps_reg;
   logic [DS_W-1:0] held_ds_reg;
   logic held_cbaux_reg;
   logic [ANA_W-1:0] held_ana_reg;
   failover_pkg::revert_state_t state_reg;
   logic src_net;
   logic net_eq_held;
   logic hw_eq_held;
   logic net_eq_hw;

   assign src_net = ctrl_reg[failover_pkg::CTRL_SRC_BIT];
   assign net_eq_held = {last_ds_reg, last_cbaux_reg} == {held_ds_reg, held_cbaux_reg};
   assign hw_eq_held = {hw_ds, hw_cbaux} == {held_ds_reg, held_cbaux_reg};
   assign net_eq_hw = {last_ds_reg, last_cbaux_reg} == {hw_ds, hw_cbaux};

   // Last valid network command, taken with each message
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         last_ds_reg <= '0;
         last_cbaux_reg <= 1'b0;
         last_ana_reg <= '0;
         last_rr_reg <= 2'h0;
         last_ps_reg <= 1'b0;
      end
      else if (msg_valid)
      begin
         last_ds_reg <= net_ds_cmd;
         last_cbaux_reg <= net_cbaux_cmd;
         last_ana_reg <= net_analog_cmd;
         // Lines are only meaningful while msg_valid is high
         last_rr_reg <= net_rr_cmd;
         last_ps_reg <= net_ps_cmd;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_reg <= failover_pkg::ST_NET;
         held_ds_reg <= '0;
         held_cbaux_reg <= 1'b0;
         held_ana_reg <= '0;
      end
      else if (!src_net)
         state_reg <= failover_pkg::ST_NET;
      else
      begin
         case (state_reg)
            failover_pkg::ST_NET:
               if (!net_ok_reg)
               begin
                  if (ctrl_reg[failover_pkg::CTRL_HOLD_BIT])
                  begin
                     state_reg <= failover_pkg::ST_HOLD;
                     held_ds_reg <= last_ds_reg;
                     held_cbaux_reg <= last_cbaux_reg;
                     held_ana_reg <= last_ana_reg;
                  end
                  else
                     state_reg <= failover_pkg::ST_REVERT;
               end
            failover_pkg::ST_REVERT:
               if (net_ok_reg)
                  state_reg <= failover_pkg::ST_NET;
            failover_pkg::ST_HOLD:
               if (net_ok_reg && net_eq_held)
                  state_reg <= failover_pkg::ST_NET;
               else if (hw_eq_held)
                  state_reg <= failover_pkg::ST_HWLOOP;
            failover_pkg::ST_HWLOOP:
               if (net_ok_reg && net_eq_hw)
                  state_reg <= failover_pkg::ST_NET;
            default: state_reg <= failover_pkg::ST_NET;
         endcase
      end
   end

   // ***************************************************
   // Command outputs
   // ***************************************************
   logic use_net_main;
   logic ds_net;
   logic cbaux_net;
   logic fast_net;

   // Hold state keeps the latched analog, and ds and cbaux where their ctrl bits are set; revert and loop states take hardware ds, cbaux and analog
   assign use_net_main = src_net & (state_reg == failover_pkg::ST_NET);
   assign ds_net = use_net_main & ctrl_reg[failover_pkg::CTRL_DS_BIT];
   assign cbaux_net = use_net_main & ctrl_reg[failover_pkg::CTRL_CBAUX_BIT];
   assign fast_net = src_net & net_ok_reg;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ds_cmd_out <= '0;
         cbaux_cmd_out <= 1'b0;
         rr_cmd_out <= 2'h0;
         ps_cmd_out <= 1'b0;
         analog_cmd_out <= '0;
      end
      else
      begin
         if (src_net && state_reg == failover_pkg::ST_HOLD)
         begin
            ds_cmd_out <= ctrl_reg[failover_pkg::CTRL_DS_BIT] ? held_ds_reg : hw_ds;
            cbaux_cmd_out <= ctrl_reg[failover_pkg::CTRL_CBAUX_BIT] ? held_cbaux_reg : hw_cbaux;
            analog_cmd_out <= held_ana_reg;
         end
         else
         begin
            ds_cmd_out <= ds_net ? last_ds_reg : hw_ds;
            cbaux_cmd_out <= cbaux_net ? last_cbaux_reg : hw_cbaux;
            analog_cmd_out <= use_net_main ? last_ana_reg : hw_analog;
         end
         rr_cmd_out <= (fast_net & ctrl_reg[failover_pkg::CTRL_RR_BIT]) ? last_rr_reg : hw_rr;
         ps_cmd_out <= (fast_net & ctrl_reg[failover_pkg::CTRL_PS_BIT]) ? last_ps_reg : hw_ps;
      end
   end

   // ***************************************************
   // Monitor and match flags
   // ***************************************************
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         input_source_monitor <= failover_pkg::MON_HARDWARE;
      else if (!src_net || !ctrl_reg[failover_pkg::CTRL_DS_BIT])
         input_source_monitor <= failover_pkg::MON_HARDWARE;
      else if (!net_ok_reg)
         input_source_monitor <= failover_pkg::MON_FAULT;
      else if (state_reg == failover_pkg::ST_NET)
         input_source_monitor <= failover_pkg::MON_NETWORK;
      else
         input_source_monitor <= failover_pkg::MON_HARDWARE;
   end

   // Both come from one state, so they cannot coincide
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         net_match_flag <= 1'b0;
         hw_match_flag <= 1'b0;
      end
      else
      begin
         net_match_flag <= src_net & (state_reg == failover_pkg::ST_HOLD);
         hw_match_flag <= src_net & (state_reg == failover_pkg::ST_HWLOOP);
      end
   end

   // ***************************************************
   // Utility breaker open output
   // ***************************************************
   // Reset and lost health both leave the output de-energized
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         breaker_open_out <= 1'b0;
      else if (!cpu_ok)
         breaker_open_out <= 1'b0;
      else if (polarity_act_reg)
         breaker_open_out <= unload;
      else
         breaker_open_out <= ~unload;
   end

endmodule // network_command_failover

`default_nettype wire

// >>> dv/failover_asserts.sv
// Purpose: Port-level checks of the failover block
// Assumes: Pin changes reach outputs within eight edges
// Notes: Bound into every instance of the block
`timescale 1ns/10ps
`default_nettype none
module failover_asserts #(parameter int DS_W = 8)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic cpu_ok_in,
   input wire logic breaker_open_out,
   input wire logic net_match_flag,
   input wire logic hw_match_flag,
   input wire logic [1:0] input_source_monitor,
   input wire logic [DS_W-1:0] hw_ds_in,
   input wire logic [DS_W-1:0] ds_cmd_out,
   input wire logic [1:0] hw_rr_in,
   input wire logic [1:0] rr_cmd_out,
   input wire logic hw_ps_in,
   input wire logic ps_cmd_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ****
   // Sequences and properties
   // ****
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_fault_hw;
      (input_source_monitor == failover_pkg::MON_FAULT && $stable(hw_rr_in) && $stable(hw_ps_in)) [*8];
   endsequence
   property p_ans; s_req |=> !avs_waitrequest; endproperty
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   property p_cpu; !cpu_ok_in [*8] |-> !breaker_open_out; endproperty
   property p_excl; !(net_match_flag && hw_match_flag); endproperty
   property p_mon; input_source_monitor != 2'h0; endproperty
   property p_rest; (input_source_monitor == failover_pkg::MON_NETWORK) [*2] |-> !net_match_flag && !hw_match_flag;
   endproperty
   property p_hold; net_match_flag [*3] |-> $stable(ds_cmd_out); endproperty
   property p_hw_loop; (hw_match_flag && $stable(hw_ds_in)) [*8] |-> ds_cmd_out == hw_ds_in; endproperty
   property p_fail_hw; s_fault_hw |-> rr_cmd_out == hw_rr_in && ps_cmd_out == hw_ps_in; endproperty
   a_ans: assert property (p_ans) else $error("no answer one cycle after request");
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low longer than one cycle");
   a_cpu: assert property (p_cpu) else $error("breaker energized without healthy cpu");
   a_excl: assert property (p_excl) else $error("both match flags set");
   a_mon: assert property (p_mon) else $error("source monitor code empty");
   a_rest: assert property (p_rest) else $error("match flag set on network");
   a_hold: assert property (p_hold) else $error("held command moved");
   a_hw_loop: assert property (p_hw_loop) else $error("hardware loop not on hardware");
   a_fail_hw: assert property (p_fail_hw) else $error("process or raise group not on hardware");
endmodule // failover_asserts
bind network_command_failover failover_asserts #(.DS_W(DS_W)) u_asserts (.ref_clk, .rst_n, .avs_read, .avs_write,
   .avs_waitrequest, .cpu_ok_in, .breaker_open_out, .net_match_flag, .hw_match_flag, .input_source_monitor,
   .hw_ds_in, .ds_cmd_out, .hw_rr_in, .rr_cmd_out, .hw_ps_in, .ps_cmd_out);
`default_nettype wire

// >>> dv/net_sender.sv
// Purpose: Network sender model, one message every gap+1 cycles
// Assumes: Messages share ref_clk with the block
// Notes: Command lines carry the inverse between messages
`timescale 1ns/10ps
`default_nettype none
module net_sender
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic [7:0] gap,
   input wire logic [23:0] val,
   output logic msg_valid,
   output logic [23:0] cmd
);
   // ****
   // Message pacing
   // ****
   logic [7:0] cnt_reg;
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cnt_reg <= 8'h00;
         msg_valid <= 1'b0;
      end
      else
      begin
         msg_valid <= en && (cnt_reg == 8'h00);
         cnt_reg <= (cnt_reg >= gap) ? 8'h00 : cnt_reg + 8'h01;
      end
   end
   // Stale lines would hide a sampling slip
   assign cmd = msg_valid ? val : ~val;
endmodule // net_sender
`default_nettype wire

// >>> dv/network_command_failover_tb_top.sv
// Purpose: Self-checking bench of the failover block
// Assumes: Ten-cycle tick, so one dropout step is ten cycles
// Notes: Reads are scored by a monitor from a queue
`timescale 1ns/10ps
`default_nettype none
module network_command_failover_tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic en = 1'b1;
   logic unload = 1'b0;
   logic cpu_ok = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [23:0] net_val = 24'h00_0000;
   logic [23:0] hw_val = 24'h00_0000;
   logic [7:0] gap = 8'h04;
   logic [19:0] seed = 20'h1_384c;
   logic [23:0] gm [4] = '{24'h00_00ff, 24'h00_0100, 24'h00_0600, 24'h00_0800};
   logic [31:0] rdata;
   logic waitreq;
   logic msg;
   logic nm;
   logic hm;
   logic brk;
   logic [1:0] mon;
   logic [23:0] cmd;
   wire logic [23:0] outs;
   logic [31:0] rd_q [$];
   int miscompares = 0;
   int total_checks = 0;
   // ****
   // Clock, block and partner
   // ****
   initial forever #10 ref_clk = ~ref_clk;
   network_command_failover #(.STEP_CYCLES(10)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(addr),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(wdata), .avs_readdata(rdata),
      .avs_waitrequest(waitreq), .msg_valid(msg), .net_ds_cmd(cmd[7:0]), .net_cbaux_cmd(cmd[8]),
      .net_rr_cmd(cmd[10:9]), .net_ps_cmd(cmd[11]), .net_analog_cmd(cmd[23:12]), .hw_ds_in(hw_val[7:0]),
      .hw_cbaux_in(hw_val[8]), .hw_rr_in(hw_val[10:9]), .hw_ps_in(hw_val[11]), .hw_analog_in(hw_val[23:12]),
      .utility_unload_in(unload), .cpu_ok_in(cpu_ok), .ds_cmd_out(outs[7:0]), .cbaux_cmd_out(outs[8]),
      .rr_cmd_out(outs[10:9]), .ps_cmd_out(outs[11]), .analog_cmd_out(outs[23:12]), .breaker_open_out(brk),
      .input_source_monitor(mon), .net_match_flag(nm), .hw_match_flag(hm));
   net_sender u_net (.ref_clk(ref_clk), .rst_n(rst_n), .en(en), .gap(gap), .val(net_val), .msg_valid(msg), .cmd(cmd));
   // ****
   // Helpers
   // ****
   function automatic logic [19:0] lfsr(input logic [19:0] s);
      return {s[18:0], s[19] ^ s[16]};
   endfunction
   function automatic logic [23:0] mix(input logic [23:0] m);
      return (hw_val & m) | (net_val & ~m);
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Read expectations are queued; the monitor scores them
   task automatic bus(input logic rd, input logic [2:0] a, input logic [31:0] d);
      if (rd)
         rd_q.push_back(d);
      @(posedge ref_clk);
      avs_read <= rd;
      avs_write <= !rd;
      addr <= a;
      wdata <= d;
      do
         @(posedge ref_clk);
      while (waitreq !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   always @(posedge ref_clk)
      if (avs_read && waitreq === 1'b0)
         chk("readdata", rd_q.pop_front(), rdata);
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic do_reset;
      @(posedge ref_clk);
      rst_n <= 1'b0;
      cyc(12);
      rst_n <= 1'b1;
      cyc(8);
   endtask
   task automatic wait_mon(input logic [1:0] code);
      while (mon !== code)
         @(posedge ref_clk);
   endtask
   task automatic brk_chk(input logic pol);
      for (int i = 0; i < 4; i++)
      begin
         unload <= i[0];
         cpu_ok <= i[1];
         cyc(8);
         chk("breaker", {31'h0000_0000, i[1] & (pol ? i[0] : !i[0])}, {31'h0000_0000, brk});
      end
      unload <= 1'b0;
      cpu_ok <= 1'b1;
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ****
   // Tests
   // ****
   initial
   begin
      do_reset;
      bus(1'b1, failover_pkg::REG_CTRL, 32'h0000_001f);
      bus(1'b1, failover_pkg::REG_DROPOUT, 32'h0000_0004);
      bus(1'b1, failover_pkg::REG_STORED, 32'h0000_0004);
      bus(1'b0, failover_pkg::REG_STATUS, 32'hffff_ffff);
      bus(1'b1, failover_pkg::REG_STATUS, 32'h0000_0406);
      brk_chk(1'b0);
      $display("test 1 done");
      seed = lfsr(lfsr(seed));
      net_val <= {seed[3:0], seed};
      hw_val <= ~{seed[3:0], seed};
      cyc(20);
      chk("outs", net_val, outs);
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b0, failover_pkg::REG_CTRL, 32'h0000_001f & ~(32'h0000_0002 << i));
         cyc(10);
         chk("outs", mix(gm[i]), outs);
         chk("monitor", i == 0 ? failover_pkg::MON_HARDWARE : failover_pkg::MON_NETWORK, mon);
      end
      bus(1'b0, failover_pkg::REG_CTRL, 32'h0000_001e);
      cyc(10);
      chk("outs", hw_val, outs);
      chk("monitor", failover_pkg::MON_HARDWARE, mon);
      $display("test 2 done");
      bus(1'b0, failover_pkg::REG_CTRL, 32'h0000_001f);
      en <= 1'b0;
      wait_mon(failover_pkg::MON_FAULT);
      en <= 1'b1;
      cyc(100);
      chk("monitor", failover_pkg::MON_FAULT, mon);
      chk("outs", hw_val, outs);
      chk("match", 32'h0000_0000, {nm, hm});
      bus(1'b1, failover_pkg::REG_STATUS, 32'h0000_0403);
      cyc(200);
      chk("monitor", failover_pkg::MON_NETWORK, mon);
      chk("outs", net_val, outs);
      $display("test 3 done");
      bus(1'b0, failover_pkg::REG_CTRL, 32'h0000_003f);
      en <= 1'b0;
      wait_mon(failover_pkg::MON_FAULT);
      cyc(10);
      chk("outs", (net_val & 24'hff_f1ff) | (hw_val & 24'h00_0e00), outs);
      chk("match", 32'h0000_0002, {nm, hm});
      hw_val[8:0] <= net_val[8:0];
      cyc(10);
      chk("match", 32'h0000_0001, {nm, hm});
      hw_val[7:0] <= ~hw_val[7:0];
      en <= 1'b1;
      cyc(300);
      chk("outs", (hw_val & 24'hff_f1ff) | (net_val & 24'h00_0e00), outs);
      chk("monitor", failover_pkg::MON_HARDWARE, mon);
      net_val[8:0] <= hw_val[8:0];
      cyc(20);
      chk("outs", net_val, outs);
      chk("match", 32'h0000_0000, {nm, hm});
      hw_val <= ~hw_val;
      en <= 1'b0;
      wait_mon(failover_pkg::MON_FAULT);
      cyc(10);
      chk("match", 32'h0000_0002, {nm, hm});
      en <= 1'b1;
      cyc(300);
      chk("match", 32'h0000_0000, {nm, hm});
      chk("monitor", failover_pkg::MON_NETWORK, mon);
      $display("test 4 done");
      bus(1'b0, failover_pkg::REG_DROPOUT, 32'h0000_0002);
      bus(1'b0, failover_pkg::REG_DROPOUT, 32'h0000_0065);
      bus(1'b1, failover_pkg::REG_DROPOUT, 32'h0000_0002);
      bus(1'b0, failover_pkg::REG_CAL_KEY, 32'h0000_0030);
      bus(1'b0, failover_pkg::REG_PHASE, 32'h0000_1234);
      bus(1'b1, failover_pkg::REG_PHASE, 32'h0000_0000);
      bus(1'b0, failover_pkg::REG_CAL_KEY, 32'h0000_0031);
      bus(1'b0, failover_pkg::REG_PHASE, 32'h0000_abcd);
      bus(1'b1, failover_pkg::REG_PHASE, 32'h0000_abcd);
      bus(1'b1, failover_pkg::REG_STORED, 32'h0000_0004);
      bus(1'b0, failover_pkg::REG_POLARITY, 32'h0000_0001);
      bus(1'b0, failover_pkg::REG_SAVE, 32'h0000_0001);
      bus(1'b1, failover_pkg::REG_STORED, 32'h00ab_cd82);
      bus(1'b1, failover_pkg::REG_STATUS, 32'h0000_0406);
      brk_chk(1'b0);
      do_reset;
      bus(1'b1, failover_pkg::REG_STATUS, 32'h0000_0226);
      brk_chk(1'b1);
      $display("test 5 done");
      end_sim;
   end
   // Tests need about 1500 cycles
   initial
   begin
      cyc(20000);
      miscompares++;
      end_sim;
   end
endmodule // network_command_failover_tb_top
`default_nettype wire
